/* rtl/rec_pkg.sv */
package rec_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 8;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OPERATION   = 8'h01;
  localparam logic [7:0] ADDR_ON_OFF_CFG  = 8'h02;
  localparam logic [7:0] ADDR_STORE_USER  = 8'h15;
  localparam logic [7:0] ADDR_HS_DUTY     = 8'h40;
  localparam logic [7:0] ADDR_REG_STATUS  = 8'h41;

  // ----------------------------------------------------------------
  // reset values and on/off config write mask
  // ----------------------------------------------------------------
  localparam logic [7:0] OPERATION_RST    = 8'h04;
  localparam logic [7:0] ON_OFF_CFG_RST   = 8'h17;
  localparam logic [7:0] HS_DUTY_RST      = 8'h40;
  localparam logic [7:0] ON_OFF_CFG_MASK  = 8'h1F;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OP_ON_BIT     = 7;
  localparam int CFG_PU_BIT    = 4;
  localparam int CFG_CMD_BIT   = 3;
  localparam int CFG_CPR_BIT   = 2;
  localparam int CFG_POL_BIT   = 1;
  localparam int ST_REG_EN     = 0;
  localparam int ST_PROG_MODE  = 1;
  localparam int ST_SS_ACTIVE  = 2;
  localparam int ST_STORE_REF  = 3;
  localparam int ST_PIN_LEVEL  = 4;

  // ----------------------------------------------------------------
  // switching timing in system clock cycles
  // ----------------------------------------------------------------
  localparam logic [7:0] PWM_PERIOD_CYC = 8'd250;
  localparam logic [7:0] SS_LS_INIT_CYC = 8'd4;
  localparam logic [7:0] SS_LS_STEP_CYC = 8'd4;

endpackage : rec_pkg

/* rtl/rec_pwm_if.sv */
`timescale 1ns/1ps
interface rec_pwm_if #(parameter int W = 8);
  logic         run;
  logic [W-1:0] hs_cycles;
  logic         ss_active;
  logic         hs_on;
  logic         ls_on;

  modport ctrl (output run, output hs_cycles, input ss_active, input hs_on, input ls_on);
  modport pwm  (input run, input hs_cycles, output ss_active, output hs_on, output ls_on);
endinterface : rec_pwm_if

/* rtl/rec_pwm_gen.sv */
`timescale 1ns/1ps
module rec_pwm_gen
  import rec_pkg::*;
#(
  parameter logic [7:0] PERIOD  = PWM_PERIOD_CYC,
  parameter logic [7:0] LS_INIT = SS_LS_INIT_CYC,
  parameter logic [7:0] LS_STEP = SS_LS_STEP_CYC
)
(
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  // link to controller
  rec_pwm_if.pwm    pif
);

  logic [7:0] cnt_ff;
  logic [7:0] ls_cap_ff;
  logic       ss_done_ff;
  logic       hs_ff;
  logic       ls_ff;
  wire  [7:0] nxt_cnt;
  wire        pulse_start;
  wire  [7:0] ls_full;
  wire  [7:0] ls_elapsed;
  wire  [8:0] cap_sum;
  wire  [7:0] nxt_ls_cap;
  wire        nxt_ss_done;
  wire        nxt_hs;
  wire        nxt_ls;

  // ----------------------------------------------------------------
  // free running period counter
  // ----------------------------------------------------------------
  // counter never stops, so the frequency stays fixed at any load
  assign nxt_cnt     = (cnt_ff == PERIOD - 8'd1) ? 8'h00 : cnt_ff + 8'd1; // RQ12
  assign pulse_start = (cnt_ff == 8'h00);
  assign ls_full     = PERIOD - pif.hs_cycles;
  assign ls_elapsed  = cnt_ff - pif.hs_cycles;

  // ----------------------------------------------------------------
  // soft start low-side limit
  // ----------------------------------------------------------------
  assign cap_sum     = {1'b0, ls_cap_ff} + {1'b0, LS_STEP};
  assign nxt_ls_cap  = !pif.run ? LS_INIT :
                       (pulse_start && !ss_done_ff) ? cap_sum[7:0] : ls_cap_ff; // RQ11
  assign nxt_ss_done = pif.run && (ss_done_ff || (ls_cap_ff >= ls_full));

  // ----------------------------------------------------------------
  // gate drive
  // ----------------------------------------------------------------
  assign nxt_hs = pif.run && (cnt_ff < pif.hs_cycles);
  // after soft start the low side fills every cycle the high side leaves
  assign nxt_ls = pif.run && (cnt_ff >= pif.hs_cycles)
                  && (ss_done_ff || (ls_elapsed < ls_cap_ff)); // RQ13

  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      cnt_ff     <= 8'h00;
      ls_cap_ff  <= LS_INIT;
      ss_done_ff <= 1'b0;
      hs_ff      <= 1'b0;
      ls_ff      <= 1'b0;
    end
    else
    begin
      cnt_ff     <= nxt_cnt;
      ls_cap_ff  <= nxt_ls_cap;
      ss_done_ff <= nxt_ss_done;
      hs_ff      <= nxt_hs;
      ls_ff      <= nxt_ls;
    end
  end

  assign pif.ss_active = pif.run && !ss_done_ff;
  assign pif.hs_on     = hs_ff;
  assign pif.ls_on     = ls_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  chk_fixed_period: assert property ( // RQ12
    cnt_ff == PERIOD - 8'd1 |=> cnt_ff == 8'h00)
    else $error("period counter did not wrap");
  chk_cap_rises: assert property ( // RQ11
    pif.run && pulse_start && !ss_done_ff |=> ls_cap_ff == $past(cap_sum[7:0]))
    else $error("low-side cap did not rise on pulse");
  chk_full_complement: assert property ( // RQ13
    $past(pif.run) && $past(ss_done_ff) && pif.run |-> hs_ff != ls_ff)
    else $error("gates not complementary after soft start");
  chk_no_overlap: assert property (
    !(hs_ff && ls_ff))
    else $error("both gates on");

endmodule : rec_pwm_gen

/* rtl/rec_regulation_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// [RQ1] register port never stalls, any bus rate
// [RQ2] programming mode: commands work, no switching
// [RQ3] commands accepted with bias below 3 V
// [RQ4] host avoids store while bias below 3 V
// [RQ5] configurable without power stage input present
// [RQ6] pin-only mode ignores operation command
// [RQ7] pin polarity chosen by on/off config
// [RQ8] threshold use needs active high polarity
// [RQ9] command-only mode ignores enable pin
// [RQ10] both mode needs pin and command
// [RQ11] soft start caps low-side, rising per pulse
// [RQ12] fixed frequency continuous conduction always; the low side is capped until soft start ends
// [RQ13] complementary gates after soft start
// [RQ14] enable evaluated each cycle, output registered
module rec_regulation_ctrl
  import rec_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  // register port
  input  wire logic [ADDR_W-1:0] i_reg_addr,
  input  wire logic [DATA_W-1:0] i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic      [DATA_W-1:0] o_reg_rdata,
  // enable pin and supply monitors
  input  wire logic              i_enable_threshold_pin,
  input  wire logic              i_analog_supply_ok,
  input  wire logic              i_bias_5v_rail_lo_ok,
  input  wire logic              i_bias_5v_rail_above_3v,
  input  wire logic              i_bias_5v_rail_conv_ok,
  input  wire logic              i_power_stage_input_ok,
  // status and control outputs
  output logic                   o_regulation_en,
  output logic                   o_programming_mode,
  output logic                   o_store_user_req,
  // gate drive
  output logic                   o_hs_gate,
  output logic                   o_ls_gate
);

  logic [7:0]        operation_ff;
  logic [7:0]        on_off_cfg_ff;
  logic [7:0]        hs_duty_ff;
  logic              store_ref_ff;
  logic              store_req_ff;
  logic              reg_en_ff;
  logic [DATA_W-1:0] rdata_ff;

  rec_pwm_if #(.W(CNT_W)) pwm_bus ();

  // ----------------------------------------------------------------
  // supply state decode
  // ----------------------------------------------------------------
  wire logic_ok  = i_analog_supply_ok && i_bias_5v_rail_lo_ok;
  wire conv_ok   = i_bias_5v_rail_conv_ok && i_power_stage_input_ok;
  wire prog_mode = logic_ok && !conv_ok; // RQ2 RQ5
  // commands only need the lower thresholds, not the 3 V level
  wire wr_ok     = i_reg_wr && logic_ok; // RQ3 RQ5

  // ----------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------
  wire wr_operation = wr_ok && (i_reg_addr == ADDR_OPERATION);
  wire wr_on_off    = wr_ok && (i_reg_addr == ADDR_ON_OFF_CFG);
  wire wr_duty      = wr_ok && (i_reg_addr == ADDR_HS_DUTY);
  wire wr_status    = wr_ok && (i_reg_addr == ADDR_REG_STATUS);
  wire wr_store     = wr_ok && (i_reg_addr == ADDR_STORE_USER);
  // a store at low bias could corrupt memory, so it is refused here too
  wire store_go     = wr_store && i_bias_5v_rail_above_3v; // RQ4
  wire store_bad    = wr_store && !i_bias_5v_rail_above_3v; // RQ4

  wire [7:0] nxt_operation = wr_operation ? i_reg_wdata : operation_ff;
  wire [7:0] nxt_on_off    = wr_on_off ? (i_reg_wdata & ON_OFF_CFG_MASK) : on_off_cfg_ff;
  wire [7:0] nxt_duty      = wr_duty ? i_reg_wdata : hs_duty_ff;
  // set wins over write-one-to-clear
  wire       nxt_store_ref = store_bad ||
                             (store_ref_ff && !(wr_status && i_reg_wdata[ST_STORE_REF]));

  // ----------------------------------------------------------------
  // enable source selection
  // ----------------------------------------------------------------
  wire cfg_pu     = on_off_cfg_ff[CFG_PU_BIT];
  wire cfg_cmd    = on_off_cfg_ff[CFG_CMD_BIT];
  wire cfg_cpr    = on_off_cfg_ff[CFG_CPR_BIT];
  wire cfg_pol_hi = on_off_cfg_ff[CFG_POL_BIT];
  wire pin_active = cfg_pol_hi ? i_enable_threshold_pin : !i_enable_threshold_pin; // RQ7
  wire op_on      = operation_ff[OP_ON_BIT];
  wire cmd_term   = cfg_cmd ? op_on : 1'b1; // RQ9 RQ10
  wire pin_term   = cfg_cpr ? pin_active : 1'b1; // RQ6 RQ10
  wire sel_on     = !cfg_pu || (cmd_term && pin_term);
  // no conversion while only the logic supplies are up
  wire nxt_reg_en = sel_on && logic_ok && conv_ok; // RQ14 RQ2

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [7:0] status_word = {3'b000, i_enable_threshold_pin, store_ref_ff,
                            pwm_bus.ss_active, prog_mode, reg_en_ff};
  wire [7:0] rd_mux = (i_reg_addr == ADDR_OPERATION)  ? operation_ff  :
                      (i_reg_addr == ADDR_ON_OFF_CFG) ? on_off_cfg_ff :
                      (i_reg_addr == ADDR_HS_DUTY)    ? hs_duty_ff    :
                      (i_reg_addr == ADDR_REG_STATUS) ? status_word   : 8'h00;
  // data only in the cycle after the strobe, zero elsewhere
  wire [7:0] nxt_rdata = i_reg_rd ? rd_mux : 8'h00; // RQ1

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      operation_ff  <= OPERATION_RST;
      on_off_cfg_ff <= ON_OFF_CFG_RST;
      hs_duty_ff    <= HS_DUTY_RST;
      store_ref_ff  <= 1'b0;
      store_req_ff  <= 1'b0;
      reg_en_ff     <= 1'b0;
      rdata_ff      <= 8'h00;
    end
    else
    begin
      operation_ff  <= nxt_operation;
      on_off_cfg_ff <= nxt_on_off;
      hs_duty_ff    <= nxt_duty;
      store_ref_ff  <= nxt_store_ref;
      store_req_ff  <= store_go;
      reg_en_ff     <= nxt_reg_en; // RQ14
      rdata_ff      <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // switching stage
  // ----------------------------------------------------------------
  // duty is clamped so the low side always gets at least one cycle
  assign pwm_bus.run       = reg_en_ff; // RQ2
  assign pwm_bus.hs_cycles = (hs_duty_ff >= PWM_PERIOD_CYC) ?
                             PWM_PERIOD_CYC - 8'd1 : hs_duty_ff;

  rec_pwm_gen #(
    .PERIOD  (PWM_PERIOD_CYC),
    .LS_INIT (SS_LS_INIT_CYC),
    .LS_STEP (SS_LS_STEP_CYC)
  ) u_pwm (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .pif       (pwm_bus)
  );

  assign o_reg_rdata        = rdata_ff;
  assign o_regulation_en    = reg_en_ff;
  assign o_programming_mode = prog_mode;
  assign o_store_user_req   = store_req_ff;
  assign o_hs_gate          = pwm_bus.hs_on;
  assign o_ls_gate          = pwm_bus.ls_on;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_pin_only;
    cfg_pu && cfg_cpr && !cfg_cmd && conv_ok && logic_ok;
  endsequence

  sequence s_cmd_only;
    cfg_pu && cfg_cmd && !cfg_cpr && conv_ok && logic_ok;
  endsequence

  chk_pin_only_mode: assert property ( // RQ6
    s_pin_only |=> reg_en_ff == $past(pin_active))
    else $error("pin-only mode did not follow pin");
  chk_pin_polarity: assert property ( // RQ7
    (s_pin_only and !cfg_pol_hi) |=> reg_en_ff == !$past(i_enable_threshold_pin))
    else $error("inverted pin polarity not honoured");
  chk_cmd_only_mode: assert property ( // RQ9
    s_cmd_only |=> reg_en_ff == $past(op_on))
    else $error("command-only mode did not follow command");
  chk_both_needed: assert property ( // RQ10
    cfg_pu && cfg_cmd && cfg_cpr && !(op_on && pin_active) |=> !reg_en_ff)
    else $error("regulation with one source missing");
  chk_prog_no_switch: assert property ( // RQ2
    prog_mode [*2] |=> !reg_en_ff && !o_hs_gate)
    else $error("switching in programming mode");
  chk_low_bias_write: assert property ( // RQ3
    i_reg_wr && logic_ok && !i_bias_5v_rail_above_3v && i_reg_addr == ADDR_OPERATION
    |=> operation_ff == $past(i_reg_wdata))
    else $error("command lost at low bias");
  chk_store_refused: assert property ( // RQ4
    store_bad |=> store_ref_ff && !store_req_ff)
    else $error("store at low bias not refused");
  chk_read_latency: assert property ( // RQ1
    i_reg_rd && i_reg_addr == ADDR_ON_OFF_CFG && !i_reg_wr
    |=> o_reg_rdata == $past(on_off_cfg_ff))
    else $error("read data not one cycle later");
  chk_en_registered: assert property ( // RQ14
    nxt_reg_en != reg_en_ff |=> reg_en_ff == $past(nxt_reg_en))
    else $error("enable change not taken next cycle");

  // ----------------------------------------------------------------
  // register port and enable checks
  // ----------------------------------------------------------------

  sequence s_prog_write;
    prog_mode && i_reg_wr;
  endsequence

  sequence s_both_on;
    cfg_pu && cfg_cmd && cfg_cpr && op_on && pin_active
    && conv_ok && logic_ok;
  endsequence

  sequence s_unmapped_rd;
    i_reg_rd && i_reg_addr != ADDR_OPERATION && i_reg_addr != ADDR_ON_OFF_CFG
    && i_reg_addr != ADDR_HS_DUTY && i_reg_addr != ADDR_REG_STATUS;
  endsequence

  chk_rdata_idle: assert property ( // RQ1
    !i_reg_rd
    |=> o_reg_rdata == 8'h00)
    else $error("read data not zero without read");
  chk_rdata_oper: assert property ( // RQ1
    i_reg_rd && i_reg_addr == ADDR_OPERATION
    |=> o_reg_rdata == $past(operation_ff))
    else $error("operation read data wrong");
  chk_rdata_duty: assert property ( // RQ1
    i_reg_rd && i_reg_addr == ADDR_HS_DUTY
    |=> o_reg_rdata == $past(hs_duty_ff))
    else $error("duty read data wrong");
  chk_rdata_status: assert property ( // RQ1
    i_reg_rd && i_reg_addr == ADDR_REG_STATUS
    |=> o_reg_rdata == $past(status_word))
    else $error("status read data wrong");
  chk_rdata_unmapped: assert property ( // RQ1
    s_unmapped_rd
    |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_write_ignored: assert property (
    i_reg_wr && !logic_ok
    |=> $stable(operation_ff) && $stable(on_off_cfg_ff) && $stable(hs_duty_ff))
    else $error("write taken without logic supplies");
  chk_prog_op_write: assert property ( // RQ2 RQ5
    (s_prog_write and (i_reg_addr == ADDR_OPERATION))
    |=> operation_ff == $past(i_reg_wdata))
    else $error("operation write lost in programming mode");
  chk_prog_cfg_write: assert property ( // RQ5
    (s_prog_write and (i_reg_addr == ADDR_ON_OFF_CFG))
    |=> on_off_cfg_ff == ($past(i_reg_wdata) & ON_OFF_CFG_MASK))
    else $error("config write lost in programming mode");
  chk_low_bias_cfg: assert property ( // RQ3
    i_reg_wr && logic_ok && !i_bias_5v_rail_above_3v && i_reg_addr == ADDR_ON_OFF_CFG
    |=> on_off_cfg_ff == ($past(i_reg_wdata) & ON_OFF_CFG_MASK))
    else $error("config write lost at low bias");
  chk_cfg_masked: assert property (
    on_off_cfg_ff[7:5] == 3'b000)
    else $error("config upper bits set");
  // back-to-back stores keep the pulse high, so only the next cycle is checked
  chk_store_pulse: assert property ( // RQ4
    store_go
    |=> o_store_user_req)
    else $error("store request missing");
  chk_store_quiet: assert property ( // RQ4
    !store_go
    |=> !o_store_user_req)
    else $error("store request without store write");
  chk_store_low_bias: assert property ( // RQ4
    !i_bias_5v_rail_above_3v
    |=> !o_store_user_req)
    else $error("store request at low bias");
  chk_refusal_sticky: assert property (
    store_ref_ff && !(wr_status && i_reg_wdata[ST_STORE_REF])
    |=> store_ref_ff)
    else $error("store refusal flag lost");
  chk_refusal_clear: assert property (
    wr_status && i_reg_wdata[ST_STORE_REF]
    |=> !store_ref_ff)
    else $error("store refusal flag not cleared");
  chk_conv_needed: assert property ( // RQ2
    !conv_ok
    |=> !o_regulation_en)
    else $error("regulation without conversion supplies");
  chk_logic_needed: assert property ( // RQ2
    !logic_ok
    |=> !o_regulation_en)
    else $error("regulation without logic supplies");
  chk_always_on: assert property ( // RQ14
    !cfg_pu && logic_ok && conv_ok
    |=> o_regulation_en)
    else $error("enable sources not ignored");
  chk_both_on: assert property ( // RQ10
    s_both_on
    |=> o_regulation_en)
    else $error("no regulation with both sources on");
  chk_cmd_ignores_pin: assert property ( // RQ9
    (s_cmd_only and (op_on && !pin_active))
    |=> o_regulation_en)
    else $error("command-only mode blocked by pin");
  chk_pin_ignores_cmd: assert property ( // RQ6
    (s_pin_only and (pin_active && !op_on))
    |=> o_regulation_en)
    else $error("pin-only mode blocked by command");
  chk_gates_idle: assert property ( // RQ2
    !reg_en_ff
    |=> !o_hs_gate && !o_ls_gate)
    else $error("gate on while regulation off");
  chk_sel_off: assert property ( // RQ14
    !sel_on
    |=> !o_regulation_en)
    else $error("regulation with source off");
  chk_prog_status: assert property ( // RQ2
    i_reg_rd && i_reg_addr == ADDR_REG_STATUS && prog_mode
    |=> o_reg_rdata[ST_PROG_MODE])
    else $error("programming mode not reported");

endmodule : rec_regulation_ctrl

/* testbench/rec_sys_model.sv */
`timescale 1ns/1ps
module rec_sys_model
  import rec_pkg::*;
(
  // clock
  input  wire logic       i_clk_sys,
  // requested state
  input  wire logic       i_pin_on,
  input  wire logic       i_pin_inv,
  input  wire logic [1:0] i_supply_lvl,
  // device pins
  output logic            o_enable_threshold_pin,
  output logic            o_analog_supply_ok,
  output logic            o_bias_5v_rail_lo_ok,
  output logic            o_bias_5v_rail_above_3v,
  output logic            o_bias_5v_rail_conv_ok,
  output logic            o_power_stage_input_ok
);
  // levels change just after an edge, like real slow monitors
  // threshold divider use keeps i_pin_inv low
  always_ff @(posedge i_clk_sys)
  begin
    o_enable_threshold_pin  <= i_pin_on ^ i_pin_inv;
    o_analog_supply_ok      <= (i_supply_lvl != 2'd0);
    o_bias_5v_rail_lo_ok    <= (i_supply_lvl != 2'd0);
    o_bias_5v_rail_above_3v <= (i_supply_lvl >= 2'd2);
    o_bias_5v_rail_conv_ok  <= (i_supply_lvl == 2'd3);
    o_power_stage_input_ok  <= (i_supply_lvl == 2'd3);
  end
endmodule : rec_sys_model

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench
  import rec_pkg::*;
;
  logic       clk, rst, wr, rd, pin_on, pin_inv;
  logic       pin, aok, blo, b3v, bconv, psok, reg_en, prog, store, hs, ls;
  logic [1:0] lvl;
  logic [7:0] addr, wdata, rdata, v, nh, nl, nb, nl1, cfg, exp_cfg;
  logic [7:0] cfgs [5] = '{8'h17, 8'h15, 8'h1B, 8'h1F, 8'h07};
  int         n_errors, tests_run;

  rec_regulation_ctrl dut_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_enable_threshold_pin(pin), .i_analog_supply_ok(aok), .i_bias_5v_rail_lo_ok(blo),
    .i_bias_5v_rail_above_3v(b3v), .i_bias_5v_rail_conv_ok(bconv),
    .i_power_stage_input_ok(psok), .o_regulation_en(reg_en), .o_programming_mode(prog),
    .o_store_user_req(store), .o_hs_gate(hs), .o_ls_gate(ls));
  rec_sys_model sys_u (.i_clk_sys(clk), .i_pin_on(pin_on), .i_pin_inv(pin_inv),
    .i_supply_lvl(lvl), .o_enable_threshold_pin(pin), .o_analog_supply_ok(aok),
    .o_bias_5v_rail_lo_ok(blo), .o_bias_5v_rail_above_3v(b3v),
    .o_bias_5v_rail_conv_ok(bconv), .o_power_stage_input_ok(psok));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, e, g);
    end
  endtask : chk
  // one idle edge between accesses, so no signal is driven twice at one edge
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // gate activity over one switching period of arbitrary phase
  task automatic win(output logic [7:0] h, output logic [7:0] l, output logic [7:0] b);
    h = 8'h00; l = 8'h00; b = 8'h00;
    repeat (250)
    begin
      tick(1);
      h = h + {7'h00, hs};
      l = l + {7'h00, ls};
      b = b + {7'h00, hs & ls};
    end
  endtask : win
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // whole run is near 13000 cycles
  initial
  begin
    #200000;
    n_errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
    pin_on = 1'b0; pin_inv = 1'b0; lvl = 2'd0; n_errors = 0; tests_run = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reg_rd(ADDR_OPERATION, v);  chk("operation reset", 8'h04, v);
    reg_rd(ADDR_ON_OFF_CFG, v); chk("on_off_cfg reset", 8'h17, v);
    reg_rd(ADDR_HS_DUTY, v);    chk("hs duty reset", 8'h40, v);
    reg_rd(ADDR_REG_STATUS, v); chk("status reset", 8'h00, v & 8'h0B);
    reg_rd(8'h7E, v);           chk("unmapped read", 8'h00, v);
    reg_wr(ADDR_OPERATION, 8'h80);
    reg_rd(ADDR_OPERATION, v);  chk("write without supply", 8'h04, v);
    $display("test reset and access done");

    lvl <= 2'd1;
    pin_on <= 1'b1;
    tick(4);
    chk("programming mode", 8'h01, {7'h00, prog});
    reg_wr(ADDR_OPERATION, 8'h80);
    reg_rd(ADDR_OPERATION, v);  chk("write below 3v", 8'h80, v);
    chk("no regulation", 8'h00, {5'h00, reg_en, hs, ls});
    reg_wr(ADDR_STORE_USER, 8'h00);
    #1 chk("store below 3v", 8'h00, {7'h00, store});
    reg_rd(ADDR_REG_STATUS, v); chk("store refused", 8'h08, v & 8'h08);
    reg_wr(ADDR_REG_STATUS, 8'h08);
    reg_rd(ADDR_REG_STATUS, v); chk("refusal cleared", 8'h00, v & 8'h08);
    lvl <= 2'd2;
    tick(3);
    reg_wr(ADDR_STORE_USER, 8'h00);
    #1 chk("store pulse", 8'h01, {7'h00, store});
    tick(1);
    chk("store pulse end", 8'h00, {7'h00, store});
    $display("test programming mode done");

    lvl <= 2'd3;
    reg_wr(ADDR_ON_OFF_CFG, 8'hFF);
    reg_rd(ADDR_ON_OFF_CFG, v); chk("cfg upper bits", 8'h1F, v);
    for (int c = 0; c < 5; c++)
      for (int k = 0; k < 4; k++)
      begin
        cfg = cfgs[c];
        reg_wr(ADDR_ON_OFF_CFG, cfg);
        reg_wr(ADDR_OPERATION, {k[1], 7'h00});
        pin_on <= k[0];
        tick(4);
        exp_cfg[0] = cfg[1] ? k[0] : !k[0];
        exp_cfg[1] = cfg[3] ? k[1] : 1'b1;
        exp_cfg[2] = cfg[2] ? exp_cfg[0] : 1'b1;
        exp_cfg[3] = !cfg[4] || (exp_cfg[1] && exp_cfg[2]);
        chk("regulation mode", {7'h00, exp_cfg[3]}, {7'h00, reg_en});
      end
    $display("test enable modes done");

    reg_wr(ADDR_ON_OFF_CFG, 8'h17);
    pin_on <= 1'b1;
    tick(4);
    chk("enable on", 8'h01, {7'h00, reg_en});
    @(posedge clk);
    pin_on <= 1'b0;
    tick(1);
    chk("enable before edge", 8'h01, {7'h00, reg_en});
    tick(1);
    chk("enable next cycle", 8'h00, {7'h00, reg_en});
    tick(2);
    chk("gates off", 8'h00, {6'h00, hs, ls});
    $display("test enable timing done");

    pin_on <= 1'b1;
    tick(3);
    win(nh, nl1, nb);
    chk("soft start cap", 8'h01, {7'h00, nl1 <= 8'd12});
    chk("soft start overlap", 8'h00, nb);
    win(nh, nl, nb);
    chk("soft start rising", 8'h01, {7'h00, nl > nl1});
    tick(12000);
    win(nh, nl, nb);
    chk("high side cycles", 8'd64, nh);
    chk("low side cycles", 8'd186, nl);
    chk("gate overlap", 8'h00, nb);
    lvl <= 2'd1;
    tick(4);
    chk("conversion lost", 8'h04, {5'h00, prog, reg_en, hs | ls});
    $display("test switching done");
    end_of_test();
  end
endmodule : testbench
